// *** logic/gpio_port_defines.svh ***
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// Register word addresses on the plain register port
`define ADDR_OUTPUT_LATCH   4'h0
`define ADDR_DIRECTION      4'h1
`define ADDR_PULLUP_SELECT  4'h2
`define ADDR_STANDBY_CTRL   4'h3

// Implemented bit positions of each port register
`define PIN_LO              1
`define PIN_HI              2
`define PORT_MASK           8'h06

// Standby control fields
`define STBY_FLOAT_BIT      0
`define STBY_STOP_BIT       1
`define STBY_WATCH_BIT      2
`define STBY_MASK           8'h07

// Reset values
`define RST_OUTPUT_LATCH    8'h00
`define RST_DIRECTION       8'h00
`define RST_PULLUP_SELECT   8'h00
`define RST_STANDBY_CTRL    8'h00

`endif

// *** logic/gpio_port_pkg.sv ***
package gpio_port_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       rmw;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe_n;
    logic [1:0] pullup_en;
  } pad_drive_t;

endpackage : gpio_port_pkg

// *** logic/pad_input_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module pad_input_sync (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [1:0] pad_in,
  output var  logic [1:0] pad_sync
);

  logic [1:0] meta;

  // The first stage feeds only the second stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta     <= 2'h0;
      pad_sync <= 2'h0;
    end else begin
      meta     <= pad_in;
      pad_sync <= meta;
    end
  end

endmodule : pad_input_sync

`default_nettype wire

// *** logic/two_pin_gpio_port_with_pullup.sv ***
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_defines.svh"

// What this block does
// RULE1: direction 1 output, 0 input
// RULE2: output pin drives its latch value
// RULE3: latch write appears on output pad
// RULE4: input pin stores latch, pad undriven
// RULE5: output pin normal read returns latch
// RULE6: input pin normal read returns pad
// RULE7: read-modify-write read returns latch contents
// RULE8: reset clears all direction bits
// RULE9: float setting plus standby forces Hi-Z
// RULE10: floated input pins block input, read low
// RULE11: float setting 0 keeps pin states
// RULE12: pull-up select 1 connects pull-up
// RULE13: low driven output drops pull-up
// RULE14: software disables shared peripheral outputs; this block has no peripheral outputs to disable
// RULE15: only bits 1 and 2 implemented
// RULE16: pad samples synchronised before reads
module two_pin_gpio_port_with_pullup (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic                    reg_rmw,
  output var  logic [7:0]              reg_rdata,
  input  wire logic [1:0]              pad_in,
  output var  logic [1:0]              pad_out,
  output var  logic [1:0]              pad_oe_n,
  output var  logic [1:0]              pad_pullup_en,
  output var  logic                    pad_input_blocked
);

  gpio_port_pkg::reg_req_t   req;
  gpio_port_pkg::pad_drive_t next_drive;
  logic [7:0]                output_latch;
  logic [7:0]                direction;
  logic [7:0]                pullup_select;
  logic [7:0]                standby_ctrl;
  logic [1:0]                pad_sync;
  logic                      float_now;
  logic [7:0]                next_rdata;
  logic [7:0]                pin_view;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;
  assign req.rmw   = reg_rmw;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] w);
    hit = (a == w);
  endfunction : hit

  pad_input_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pad_in   (pad_in),
    .pad_sync (pad_sync)  // [RULE16]
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      output_latch <= `RST_OUTPUT_LATCH;
    end else if (req.wr && hit(req.addr, `ADDR_OUTPUT_LATCH)) begin
      // Stored regardless of direction [RULE3] [RULE4] [RULE15]
      output_latch <= req.wdata & `PORT_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      direction <= `RST_DIRECTION;  // [RULE8]
    end else if (req.wr && hit(req.addr, `ADDR_DIRECTION)) begin
      direction <= req.wdata & `PORT_MASK;  // [RULE15]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pullup_select <= `RST_PULLUP_SELECT;
    end else if (req.wr && hit(req.addr, `ADDR_PULLUP_SELECT)) begin
      pullup_select <= req.wdata & `PORT_MASK;  // [RULE15]
    end
  end

  // Stand-in for the chip's standby controller
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standby_ctrl <= `RST_STANDBY_CTRL;
    end else if (req.wr && hit(req.addr, `ADDR_STANDBY_CTRL)) begin
      standby_ctrl <= req.wdata & `STBY_MASK;
    end
  end

  // Float only in stop or watch with float setting set [RULE9] [RULE11]
  assign float_now = standby_ctrl[`STBY_FLOAT_BIT] &
                     (standby_ctrl[`STBY_STOP_BIT] |
                      standby_ctrl[`STBY_WATCH_BIT]);

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_pin
      localparam int B = `PIN_LO + i;
      // Continuous assigns: each bit has one driver, no shared process
      assign next_drive.out[i]  = output_latch[B];  // [RULE2] [RULE3]
      // Low enable drives; input or float leaves pad free
      assign next_drive.oe_n[i] = ~direction[B] | float_now;  // [RULE1] [RULE4] [RULE9]
      // Pull-up off whenever the pad is driven low [RULE12] [RULE13]
      assign next_drive.pullup_en[i] = pullup_select[B] &
                                       ~(direction[B] & ~float_now &
                                         ~output_latch[B]);
      // Output reads latch; input reads pad, blocked input reads low
      assign pin_view[B] = direction[B] ? output_latch[B]  // [RULE5]
                         : (pad_sync[i] & ~float_now);     // [RULE6] [RULE10]
    end
  endgenerate

  assign pin_view[0]   = 1'b0;
  assign pin_view[7:3] = 5'h00;

  always_comb begin
    next_rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `ADDR_OUTPUT_LATCH: begin
          next_rdata = req.rmw ? output_latch : pin_view;  // [RULE7]
        end
        `ADDR_DIRECTION:     next_rdata = direction;
        `ADDR_PULLUP_SELECT: next_rdata = pullup_select;
        `ADDR_STANDBY_CTRL:  next_rdata = standby_ctrl;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Pad controls registered; one cycle after the register write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pad_out           <= 2'h0;
      pad_oe_n          <= 2'h3;
      pad_pullup_en     <= 2'h0;
      pad_input_blocked <= 1'b0;
    end else begin
      pad_out           <= next_drive.out;
      pad_oe_n          <= next_drive.oe_n;
      pad_pullup_en     <= next_drive.pullup_en;
      pad_input_blocked <= float_now;  // [RULE10]
    end
  end

endmodule : two_pin_gpio_port_with_pullup

`default_nettype wire

// *** tb/gpio_port_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module gpio_port_monitor (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_rmw,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] pad_out,
  input wire logic [1:0] pad_oe_n,
  input wire logic [1:0] pad_pullup_en,
  input wire logic       pad_input_blocked
);
  logic [1:0] lat, dir, sel, q, drv;
  logic [2:0] stb;
  logic       flt, rdl;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  assign flt = stb[0] & (stb[1] | stb[2]);
  assign drv = dir & ~{2{flt}};
  assign rdl = reg_rd && reg_addr == 4'h0;
  // Pads are registered; judge them only once writes have settled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) q <= 2'h0;
    else if (reg_wr) q <= 2'h0;
    else if (q != 2'h3) q <= q + 2'h1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) {lat, dir, sel, stb} <= 9'h000;
    else if (reg_wr) case (reg_addr)
      4'h0: lat <= reg_wdata[2:1];
      4'h1: dir <= reg_wdata[2:1];
      4'h2: sel <= reg_wdata[2:1];
      4'h3: stb <= reg_wdata[2:0];
      default: ;
    endcase
  end
  a_oe_dir:
    assert property (q == 2'h3 |-> pad_oe_n == ~drv) else $error("oe bad");
  a_out_latch:
    assert property (q == 2'h3 |-> pad_out == lat) else $error("out bad");
  a_pullup_sel:
    assert property (q == 2'h3 |-> pad_pullup_en == (sel & ~(drv & ~lat)))
      else $error("pullup bad");
  a_block_flag:
    assert property (q == 2'h3 |-> pad_input_blocked == flt)
      else $error("block bad");
  a_rmw_latch:
    assert property (rdl && reg_rmw |=> reg_rdata == {5'h00, lat, 1'b0})
      else $error("rmw read bad");
  a_out_read:
    assert property (rdl && !reg_rmw && dir == 2'h3
      |=> reg_rdata == {5'h00, lat, 1'b0}) else $error("out read bad");
  a_float_low:
    assert property (q == 2'h3 && flt && dir == 2'h0 && rdl && !reg_rmw
      |=> reg_rdata == 8'h00) else $error("float read bad");
  a_spare_zero:
    assert property (reg_rd && reg_addr != 4'h3 |=> (reg_rdata & 8'hF9) == 8'h00)
      else $error("spare bits bad");
  c_float: cover property (pad_input_blocked);
  c_rmw: cover property (rdl && reg_rmw);
  c_low_pu: cover property (q == 2'h3 && |(sel & drv & ~lat));
endmodule : gpio_port_monitor
bind two_pin_gpio_port_with_pullup gpio_port_monitor u_mon (.*);
`default_nettype wire

// *** tb/pad_pins.sv ***
`timescale 1ns/100ps
`default_nettype none
module pad_pins (
  input  wire logic [1:0] pad_out,
  input  wire logic [1:0] pad_oe_n,
  input  wire logic [1:0] pad_pullup_en,
  input  wire logic       ext_en,
  input  wire logic [1:0] ext_val,
  output var  logic [1:0] pad_in
);
  // Undriven, unpulled and no external drive: show the inverse of pad_out, the output latch value
  always_comb
    for (int i = 0; i < 2; i++)
      pad_in[i] = !pad_oe_n[i] ? pad_out[i]
                : ext_en ? ext_val[i]
                : pad_pullup_en[i] | ~pad_out[i];
endmodule : pad_pins
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        reg_rmw = 1'b0;
  logic        ext_en = 1'b1;
  logic        pad_input_blocked, flt;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [1:0]  pad_in, pad_out, pad_oe_n, pad_pullup_en, drv, pue;
  logic [1:0]  ext_val = 2'h0;
  logic [1:0]  lat = 2'h0, dir = 2'h0, sel = 2'h0;
  logic [2:0]  stb = 3'h0;
  logic [31:0] rnd = 32'hB401;
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;
  two_pin_gpio_port_with_pullup u_two_pin_gpio_port_with_pullup (.*);
  pad_pins u_pad_pins (.*);
  assign flt = stb[0] & (stb[1] | stb[2]);
  assign drv = dir & ~{2{flt}};
  assign pue = sel & ~(drv & ~lat);
  function automatic logic [7:0] exp_rd(input logic m);
    logic [1:0] lvl;
    lvl = (ext_en ? ext_val : pue) & ~{2{flt}};
    return {5'h00, m ? lat : (dir & lat) | (~dir & lvl), 1'b0};
  endfunction : exp_rd
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == 4'h0) lat = v[2:1];
    if (a == 4'h1) dir = v[2:1];
    if (a == 4'h2) sel = v[2:1];
    if (a == 4'h3) stb = v[2:0];
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic m, input logic [7:0] e);
    @(posedge core_clk);
    {reg_rd, reg_rmw, reg_addr} <= {1'b1, m, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK("read", e, reg_rdata)
  endtask : rchk
  task automatic pads();
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("oe_n", ~drv, pad_oe_n)
    `CHK("out", lat, pad_out)
    `CHK("pullup", pue, pad_pullup_en)
    `CHK("blocked", flt, pad_input_blocked)
  endtask : pads
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    pads();
    rchk(4'h1, 1'b0, 8'h00);
    wreg(4'h2, 8'hFF);
    rchk(4'h2, 1'b0, 8'h06);
    wreg(4'hF, 8'hFF);
    rchk(4'hF, 1'b0, 8'h00);
    ext_en <= 1'b0;
    pads();
    rchk(4'h0, 1'b0, exp_rd(1'b0));
    ext_en <= 1'b1;
    repeat (150) begin
      rnd = lfsr(rnd);
      ext_val <= rnd[9:8];
      wreg({2'h0, rnd[1:0]}, rnd[17:10]);
      pads();
      rchk(4'h0, 1'b0, exp_rd(1'b0));
      rchk(4'h0, 1'b1, exp_rd(1'b1));
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
